// >>> logic/rie_pkg.sv
// package: register map, event bit layout and command fields of the terminal-2 interrupt event block
package rie_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // word indices of the shared registers; byte address is four times the index
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
  localparam logic [5:0] IDX_IRQ_PENDING = 6'h09;
  localparam logic [5:0] IDX_IRQ_OUTPUT_ENABLE = 6'h16;
  localparam logic [5:0] IDX_T2_CONFIG = 6'h20;

  // register byte offsets; table words differ in address bit 2
  localparam logic [7:0] OFS_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'h0};
  localparam logic [7:0] OFS_IRQ_PENDING = {IDX_IRQ_PENDING, 2'h0};
  localparam logic [7:0] OFS_IRQ_OUTPUT_ENABLE = {IDX_IRQ_OUTPUT_ENABLE, 2'h0};
  localparam logic [7:0] OFS_T2_CONFIG = {IDX_T2_CONFIG, 2'h0};
  localparam logic [7:0] OFS_CIRC_PRESET = 8'h04;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h0C;
  localparam logic [7:0] OFS_ILLEGAL_TABLE0 = 8'h10;
  localparam logic [7:0] OFS_ILLEGAL_TABLE1 = 8'h14;

  // shared event bit positions
  localparam int BIT_RESET_MODE_CMD = 15;
  localparam int BIT_INDEX_ZERO = 14;
  localparam int BIT_ILLEGAL_CMD = 13;
  localparam int BIT_BCAST_RECEIVED = 12;
  localparam logic [15:0] REG_WRITABLE_MASK = 16'hFDFF;

  // configuration fields
  localparam int CFG_AUTO_RESET_BIT = 0;
  localparam int CFG_BCAST_ENABLE_BIT = 1;
  localparam logic [1:0] CFG_WRITABLE_MASK = 2'h3;

  // reset values
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [1:0] RST_CONFIG = 2'h0;
  localparam logic [7:0] RST_PRESET = 8'h00;

  // command word decode
  localparam logic [4:0] BCAST_ADDR = 5'h1F;
  localparam logic [4:0] MODE_SA_LOW = 5'h00;
  localparam logic [4:0] MODE_SA_HIGH = 5'h1F;
  localparam logic [4:0] MODE_CODE_RESET = 5'h08;
  localparam logic [7:0] INDEX_LAST = 8'h01;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // received command word
  typedef struct packed {
    logic [4:0] rt_addr;
    logic xmit;
    logic [4:0] subaddr;
    logic [4:0] count;
  } rie_cmd_t;

  // write request for one word of the illegalization table
  typedef struct packed {
    logic wr_en;
    logic wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
  } rie_tbl_wr_t;
endpackage : rie_pkg

// >>> logic/rie_illegal_table.sv
// illegalization table: two words of command-illegal bits, registered bus and lookup reads
`timescale 1ns/10ps
module rie_illegal_table (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bus side
  input wire rie_pkg::rie_tbl_wr_t wr_in,
  input wire logic rd_idx_in,
  output logic [31:0] rd_data_out,
  // command lookup, {xmit, subaddr}
  input wire logic [5:0] look_idx_in,
  output logic illegal_out
);
  logic [31:0] mem_q [2];
  logic [31:0] mem_d [2];
  logic [31:0] rd_data_d;
  logic illegal_d;

  always_comb begin
    mem_d = mem_q;
    for (int b = 0; b < 4; b++) begin
      if (wr_in.wr_en && wr_in.wr_strb[b]) begin
        mem_d[wr_in.wr_idx][b*8 +: 8] = wr_in.wr_data[b*8 +: 8];
      end
    end
    rd_data_d = mem_q[rd_idx_in];
    // a one marks the command illegal, zero legal
    illegal_d = mem_q[look_idx_in[5]][look_idx_in[4:0]];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_q[0] <= 32'h0000_0000;
      mem_q[1] <= 32'h0000_0000;
      rd_data_out <= 32'h0000_0000;
      illegal_out <= 1'b0;
    end else begin
      mem_q <= mem_d;
      rd_data_out <= rd_data_d;
      illegal_out <= illegal_d;
    end
  end
endmodule : rie_illegal_table

// >>> logic/rie_event_bits.sv
// terminal-2 interrupt event bits with pending, enable, output-enable registers over axi4-lite
`timescale 1ns/10ps
module rie_event_bits (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic [2:0] S_AXI_AWPROT_IN,
  // axi4-lite write data
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  // axi4-lite write response
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic [2:0] S_AXI_ARPROT_IN,
  // axi4-lite read data
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  // terminal-2 message engine
  input wire logic [4:0] T2_ADDR_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [15:0] CMD_WORD_IN,
  input wire logic MSG_DONE_IN,
  // buffer index tracking
  input wire logic BUF_STEP_IN,
  input wire logic BUF_CIRC_IN,
  input wire logic [7:0] BUF_INDEX_IN,
  // terminal reset requests
  output logic T1_RESET_MODE_CMD_REQUEST_OUT,
  output logic T2_RESET_MODE_CMD_REQUEST_OUT,
  output logic T2_AUTO_RESET_OUT,
  // status response control
  output logic T2_ME_RESPONSE_OUT,
  // interrupt log and host interrupts
  output logic LOG_WR_OUT,
  output logic [15:0] LOG_WORD_OUT,
  output logic IRQ_N_OUT,
  output logic INT_OUT
);
  // bus slave state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rd_pend_q, rd_pend_d;
  logic [7:0] rd_addr_q, rd_addr_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic do_write;
  logic aw_hs;
  logic w_hs;
  logic rd_clr;
  logic [15:0] w16;
  logic [15:0] w1c;
  rie_pkg::rie_tbl_wr_t tbl_wr;
  logic [31:0] tbl_rd_data;

  // register state
  logic [15:0] enable_q, enable_d;
  logic [15:0] pending_q, pending_d;
  logic [15:0] outen_q, outen_d;
  logic [1:0] config_q, config_d;
  logic [7:0] preset_q, preset_d;
  logic [15:0] status_q, status_d;
  logic [15:0] mask_q, mask_d;

  // event state
  rie_pkg::rie_cmd_t cmd_in;
  rie_pkg::rie_cmd_t cmd_q, cmd_d;
  logic cmd_v_q, cmd_v_d;
  logic illegal;
  logic [7:0] circ_cnt_q, circ_cnt_d;
  logic msg_hit_q, msg_hit_d;
  logic irq_n_q, irq_n_d;
  logic int_q, int_d;
  logic t1_req_q, t1_req_d;
  logic t2_req_q, t2_req_d;
  logic auto_q, auto_d;
  logic me_q, me_d;
  logic log_wr_q, log_wr_d;
  logic [15:0] log_word_q, log_word_d;
  logic to_t2, bcast, bcast_ok, accepted, mode8;
  logic [15:0] ev_raw, ev_en;

  assign cmd_in = rie_pkg::rie_cmd_t'(CMD_WORD_IN);

  // table lookup is registered, so the command is held one cycle to meet it
  rie_illegal_table u_table (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_in(tbl_wr),
    .rd_idx_in(S_AXI_ARADDR_IN[2]),
    .rd_data_out(tbl_rd_data),
    .look_idx_in({cmd_in.xmit, cmd_in.subaddr}),
    .illegal_out(illegal)
  );

  // command decode and events
  always_comb begin
    cmd_d = cmd_in;
    cmd_v_d = CMD_VALID_IN;
    to_t2 = (cmd_q.rt_addr == T2_ADDR_IN);
    bcast = (cmd_q.rt_addr == rie_pkg::BCAST_ADDR);
    bcast_ok = bcast && config_q[rie_pkg::CFG_BCAST_ENABLE_BIT];
    accepted = cmd_v_q && (to_t2 || bcast_ok);
    mode8 = cmd_q.xmit && (cmd_q.count == rie_pkg::MODE_CODE_RESET) &&
      (cmd_q.subaddr == rie_pkg::MODE_SA_LOW || cmd_q.subaddr == rie_pkg::MODE_SA_HIGH);
    ev_raw = 16'h0000;
    ev_raw[rie_pkg::BIT_RESET_MODE_CMD] = accepted && mode8 && !illegal;
    ev_raw[rie_pkg::BIT_ILLEGAL_CMD] = accepted && illegal;
    ev_raw[rie_pkg::BIT_BCAST_RECEIVED] = cmd_v_q && bcast_ok;
    circ_cnt_d = circ_cnt_q;
    if (BUF_STEP_IN && !BUF_CIRC_IN && BUF_INDEX_IN == rie_pkg::INDEX_LAST) begin
      ev_raw[rie_pkg::BIT_INDEX_ZERO] = 1'b1;
    end
    // preset of zero never fires, the count just stays put
    if (BUF_STEP_IN && BUF_CIRC_IN && preset_q != rie_pkg::RST_PRESET) begin
      if (circ_cnt_q + 8'h01 == preset_q) begin
        ev_raw[rie_pkg::BIT_INDEX_ZERO] = 1'b1;
        circ_cnt_d = 8'h00;
      end else begin
        circ_cnt_d = circ_cnt_q + 8'h01;
      end
    end
    ev_en = ev_raw & enable_q;
    // reset pins ignore the enable bit; broadcast drives both terminals
    t2_req_d = ev_raw[rie_pkg::BIT_RESET_MODE_CMD];
    t1_req_d = ev_raw[rie_pkg::BIT_RESET_MODE_CMD] && bcast;
    auto_d = ev_raw[rie_pkg::BIT_RESET_MODE_CMD] && config_q[rie_pkg::CFG_AUTO_RESET_BIT];
    // broadcast gets no status word, so only addressed commands answer
    me_d = ev_raw[rie_pkg::BIT_ILLEGAL_CMD] && to_t2 && !bcast;
  end

  // bus slave next state
  always_comb begin
    aw_hs = S_AXI_AWVALID_IN && awready_q;
    w_hs = S_AXI_WVALID_IN && wready_q;
    do_write = aw_have_q && w_have_q && !bvalid_q;
    awaddr_d = aw_hs ? S_AXI_AWADDR_IN : awaddr_q;
    wdata_d = w_hs ? S_AXI_WDATA_IN : wdata_q;
    wstrb_d = w_hs ? S_AXI_WSTRB_IN : wstrb_q;
    aw_have_d = do_write ? 1'b0 : (aw_have_q || aw_hs);
    w_have_d = do_write ? 1'b0 : (w_have_q || w_hs);
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (bvalid_q && S_AXI_BREADY_IN) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = rie_pkg::RESP_SLVERR;
      case (awaddr_q)
        rie_pkg::OFS_IRQ_ENABLE, rie_pkg::OFS_IRQ_PENDING, rie_pkg::OFS_IRQ_OUTPUT_ENABLE,
        rie_pkg::OFS_T2_CONFIG, rie_pkg::OFS_CIRC_PRESET, rie_pkg::OFS_EVENT_STATUS,
        rie_pkg::OFS_EVENT_MASK, rie_pkg::OFS_ILLEGAL_TABLE0, rie_pkg::OFS_ILLEGAL_TABLE1: begin
          bresp_d = rie_pkg::RESP_OKAY;
        end
        default: begin
          bresp_d = rie_pkg::RESP_SLVERR;
        end
      endcase
    end
    w16 = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
    w1c = do_write && awaddr_q == rie_pkg::OFS_EVENT_STATUS ? w16 : 16'h0000;
    tbl_wr.wr_en = do_write &&
      (awaddr_q == rie_pkg::OFS_ILLEGAL_TABLE0 || awaddr_q == rie_pkg::OFS_ILLEGAL_TABLE1);
    tbl_wr.wr_idx = awaddr_q[2];
    tbl_wr.wr_data = wdata_q;
    tbl_wr.wr_strb = wstrb_q;
    rd_pend_d = 1'b0;
    rd_addr_d = rd_addr_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (S_AXI_ARVALID_IN && arready_q) begin
      rd_pend_d = 1'b1;
      rd_addr_d = S_AXI_ARADDR_IN;
    end
    if (rvalid_q && S_AXI_RREADY_IN) begin
      rvalid_d = 1'b0;
    end
    rd_clr = rd_pend_q && rd_addr_q == rie_pkg::OFS_IRQ_PENDING;
    if (rd_pend_q) begin
      rvalid_d = 1'b1;
      rresp_d = rie_pkg::RESP_OKAY;
      case (rd_addr_q)
        rie_pkg::OFS_IRQ_ENABLE: rdata_d = {16'h0000, enable_q};
        rie_pkg::OFS_IRQ_PENDING: rdata_d = {16'h0000, pending_q};
        rie_pkg::OFS_IRQ_OUTPUT_ENABLE: rdata_d = {16'h0000, outen_q};
        rie_pkg::OFS_T2_CONFIG: rdata_d = {30'h0000_0000, config_q};
        rie_pkg::OFS_CIRC_PRESET: rdata_d = {24'h00_0000, preset_q};
        rie_pkg::OFS_EVENT_STATUS: rdata_d = {16'h0000, status_q};
        rie_pkg::OFS_EVENT_MASK: rdata_d = {16'h0000, mask_q};
        rie_pkg::OFS_ILLEGAL_TABLE0, rie_pkg::OFS_ILLEGAL_TABLE1: rdata_d = tbl_rd_data;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = rie_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rd_pend_d && !rvalid_d;
  end

  // register file and interrupt next state
  always_comb begin
    enable_d = enable_q;
    outen_d = outen_q;
    config_d = config_q;
    preset_d = preset_q;
    mask_d = mask_q;
    if (do_write) begin
      case (awaddr_q)
        rie_pkg::OFS_IRQ_ENABLE: enable_d = w16 & rie_pkg::REG_WRITABLE_MASK;
        rie_pkg::OFS_IRQ_OUTPUT_ENABLE: outen_d = w16 & rie_pkg::REG_WRITABLE_MASK;
        rie_pkg::OFS_T2_CONFIG: config_d = w16[1:0] & rie_pkg::CFG_WRITABLE_MASK;
        rie_pkg::OFS_CIRC_PRESET: preset_d = w16[7:0];
        rie_pkg::OFS_EVENT_MASK: mask_d = w16 & rie_pkg::REG_WRITABLE_MASK;
        default: begin
          enable_d = enable_q;
        end
      endcase
    end
    // a read clears pending, but an event in that cycle is kept
    pending_d = (rd_clr ? rie_pkg::RST_REG16 : pending_q) | ev_en;
    status_d = (status_q & ~w1c) | ev_raw;
    int_d = |(status_d & mask_q);
    log_wr_d = |ev_en;
    log_word_d = pending_d;
    // irq waits for message completion; host read of pending releases it
    msg_hit_d = (MSG_DONE_IN ? 1'b0 : msg_hit_q) || |(ev_en & outen_q);
    irq_n_d = irq_n_q;
    if (rd_clr) begin
      irq_n_d = 1'b1;
    end
    if (MSG_DONE_IN && (msg_hit_q || |(ev_en & outen_q))) begin
      irq_n_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      enable_q <= rie_pkg::RST_REG16;
      pending_q <= rie_pkg::RST_REG16;
      outen_q <= rie_pkg::RST_REG16;
      config_q <= rie_pkg::RST_CONFIG;
      preset_q <= rie_pkg::RST_PRESET;
      status_q <= rie_pkg::RST_REG16;
      mask_q <= rie_pkg::RST_REG16;
      cmd_q <= '0;
      cmd_v_q <= 1'b0;
      circ_cnt_q <= 8'h00;
      msg_hit_q <= 1'b0;
      irq_n_q <= 1'b1;
      int_q <= 1'b0;
      t1_req_q <= 1'b0;
      t2_req_q <= 1'b0;
      auto_q <= 1'b0;
      me_q <= 1'b0;
      log_wr_q <= 1'b0;
      log_word_q <= rie_pkg::RST_REG16;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      enable_q <= enable_d;
      pending_q <= pending_d;
      outen_q <= outen_d;
      config_q <= config_d;
      preset_q <= preset_d;
      status_q <= status_d;
      mask_q <= mask_d;
      cmd_q <= cmd_d;
      cmd_v_q <= cmd_v_d;
      circ_cnt_q <= circ_cnt_d;
      msg_hit_q <= msg_hit_d;
      irq_n_q <= irq_n_d;
      int_q <= int_d;
      t1_req_q <= t1_req_d;
      t2_req_q <= t2_req_d;
      auto_q <= auto_d;
      me_q <= me_d;
      log_wr_q <= log_wr_d;
      log_word_q <= log_word_d;
    end
  end

  // outputs straight from flops
  assign S_AXI_AWREADY_OUT = awready_q;
  assign S_AXI_WREADY_OUT = wready_q;
  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_BRESP_OUT = bresp_q;
  assign S_AXI_ARREADY_OUT = arready_q;
  assign S_AXI_RVALID_OUT = rvalid_q;
  assign S_AXI_RDATA_OUT = rdata_q;
  assign S_AXI_RRESP_OUT = rresp_q;
  assign T1_RESET_MODE_CMD_REQUEST_OUT = t1_req_q;
  assign T2_RESET_MODE_CMD_REQUEST_OUT = t2_req_q;
  assign T2_AUTO_RESET_OUT = auto_q;
  assign T2_ME_RESPONSE_OUT = me_q;
  assign LOG_WR_OUT = log_wr_q;
  assign LOG_WORD_OUT = log_word_q;
  assign IRQ_N_OUT = irq_n_q;
  assign INT_OUT = int_q;
endmodule : rie_event_bits

// >>> verification/rie_event_bits_assertions.sv
// checker: event, reset-pin and interrupt relations at the block ports
`timescale 1ns/10ps
module rie_event_bits_assertions (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // watched ports
  input wire logic S_AXI_RVALID_OUT,
  input wire logic [4:0] T2_ADDR_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [15:0] CMD_WORD_IN,
  input wire logic MSG_DONE_IN,
  input wire logic BUF_STEP_IN,
  input wire logic T1_RESET_MODE_CMD_REQUEST_OUT,
  input wire logic T2_RESET_MODE_CMD_REQUEST_OUT,
  input wire logic T2_AUTO_RESET_OUT,
  input wire logic T2_ME_RESPONSE_OUT,
  input wire logic LOG_WR_OUT,
  input wire logic [15:0] LOG_WORD_OUT,
  input wire logic IRQ_N_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  logic mode8;
  logic bcast;
  logic own;
  logic mode8_me;
  assign mode8 = CMD_VALID_IN && CMD_WORD_IN[10] && CMD_WORD_IN[4:0] == 5'h08
    && (CMD_WORD_IN[9:5] == 5'h00 || CMD_WORD_IN[9:5] == 5'h1F);
  assign bcast = CMD_VALID_IN && CMD_WORD_IN[15:11] == 5'h1F;
  assign own = CMD_VALID_IN && CMD_WORD_IN[15:11] == T2_ADDR_IN;
  assign mode8_me = mode8 && (own || bcast);
  sequence s_bcast_cmd;
    bcast;
  endsequence
  sequence s_irq_drop;
    $fell(IRQ_N_OUT);
  endsequence
  a_t2_req_cause: assert property (T2_RESET_MODE_CMD_REQUEST_OUT |-> $past(mode8_me, 2))
    else $error("t2 reset request without mode 8 command");
  a_auto_with_req: assert property (T2_AUTO_RESET_OUT |-> T2_RESET_MODE_CMD_REQUEST_OUT)
    else $error("automatic reset without reset request");
  a_both_pins: assert property (T1_RESET_MODE_CMD_REQUEST_OUT |-> T2_RESET_MODE_CMD_REQUEST_OUT
    && $past(bcast, 2))
    else $error("t1 request without broadcast on both pins");
  a_me_cause: assert property (T2_ME_RESPONSE_OUT |-> $past(own, 2))
    else $error("message error response without addressed command");
  a_bcast_no_me: assert property (s_bcast_cmd |-> ##2 !T2_ME_RESPONSE_OUT)
    else $error("message error response to broadcast");
  a_log_word: assert property (LOG_WR_OUT |-> LOG_WORD_OUT != 16'h0000 && !LOG_WORD_OUT[9])
    else $error("log word empty or reserved bit set");
  a_log_cause: assert property (LOG_WR_OUT |-> $past(CMD_VALID_IN, 2) || $past(BUF_STEP_IN)
    || $past(BUF_STEP_IN, 2))
    else $error("log write without event");
  a_irq_at_done: assert property (s_irq_drop |-> $past(MSG_DONE_IN))
    else $error("irq asserted outside message completion");
  a_irq_release: assert property ($rose(IRQ_N_OUT) |-> $rose(S_AXI_RVALID_OUT))
    else $error("irq released without host read");
endmodule : rie_event_bits_assertions

bind rie_event_bits rie_event_bits_assertions rie_event_bits_assertions_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .T2_ADDR_IN(T2_ADDR_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_WORD_IN(CMD_WORD_IN), .MSG_DONE_IN(MSG_DONE_IN), .BUF_STEP_IN(BUF_STEP_IN),
  .T1_RESET_MODE_CMD_REQUEST_OUT(T1_RESET_MODE_CMD_REQUEST_OUT),
  .T2_RESET_MODE_CMD_REQUEST_OUT(T2_RESET_MODE_CMD_REQUEST_OUT), .T2_AUTO_RESET_OUT(T2_AUTO_RESET_OUT),
  .T2_ME_RESPONSE_OUT(T2_ME_RESPONSE_OUT), .LOG_WR_OUT(LOG_WR_OUT), .LOG_WORD_OUT(LOG_WORD_OUT),
  .IRQ_N_OUT(IRQ_N_OUT));

// >>> verification/rie_bc_model.sv
// bus controller model: one command word, then message completion after a gap
`timescale 1ns/10ps
module rie_bc_model (
  input wire logic clk_in,
  output logic cmd_valid_out,
  output logic [15:0] cmd_word_out,
  output logic msg_done_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_word_out = 16'h0000;
    msg_done_out = 1'b0;
  end
  // word is inverted after the pulse so a stale value is never mistaken for a command
  task automatic send(input logic [15:0] word, input int gap);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_word_out <= word;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_word_out <= ~word;
    repeat (gap + 2) @(posedge clk_in);
    msg_done_out <= 1'b1;
    @(posedge clk_in);
    msg_done_out <= 1'b0;
  endtask : send
endmodule : rie_bc_model

// >>> verification/rie_event_bits_tb.sv
// testbench for the terminal-2 interrupt event block
`timescale 1ns/10ps
module rie_event_bits_tb;
  typedef struct packed {
    logic [15:0] word;
    logic t1;
    logic t2;
    logic me;
    logic [15:0] pend;
  } rie_row_t;
  logic clk, rst, awv, wv, bready, arv, rready, awr, wr_rdy, bv, arr, rv, cmd_v, done, step, circ;
  logic t1_req, t2_req, auto_r, me, log_wr, irq_n, int_o, s_t1, s_t2, s_auto, s_me, s_log;
  logic [7:0] awaddr, araddr, idx;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r;
  logic [4:0] t2_addr;
  logic [15:0] cmd_w, log_w, s_word;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  // terminal address 5; table marks receive subaddress 3 illegal
  rie_row_t rows [7] = '{'{16'h2C08, 1'b0, 1'b1, 1'b0, 16'h8000}, '{16'hFFE8, 1'b1, 1'b1, 1'b0, 16'h9000},
    '{16'h2862, 1'b0, 1'b0, 1'b1, 16'h2000}, '{16'h2882, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'hF882, 1'b0, 1'b0, 1'b0, 16'h1000}, '{16'hF862, 1'b0, 1'b0, 1'b0, 16'h3000},
    '{16'h3062, 1'b0, 1'b0, 1'b0, 16'h0000}};

  rie_bc_model rie_bc_model_i (.clk_in(clk), .cmd_valid_out(cmd_v), .cmd_word_out(cmd_w), .msg_done_out(done));
  rie_event_bits rie_event_bits_i (.CLK_IN(clk), .RST_IN(rst), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWPROT_IN(3'h0), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_rdy),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARPROT_IN(3'h0), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .T2_ADDR_IN(t2_addr), .CMD_VALID_IN(cmd_v), .CMD_WORD_IN(cmd_w),
    .MSG_DONE_IN(done), .BUF_STEP_IN(step), .BUF_CIRC_IN(circ), .BUF_INDEX_IN(idx),
    .T1_RESET_MODE_CMD_REQUEST_OUT(t1_req), .T2_RESET_MODE_CMD_REQUEST_OUT(t2_req), .T2_AUTO_RESET_OUT(auto_r),
    .T2_ME_RESPONSE_OUT(me), .LOG_WR_OUT(log_wr), .LOG_WORD_OUT(log_w), .IRQ_N_OUT(irq_n), .INT_OUT(int_o));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulses last one cycle, so they are caught into sticky flags
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (t1_req === 1'b1) s_t1 <= 1'b1;
    if (t2_req === 1'b1) s_t2 <= 1'b1;
    if (auto_r === 1'b1) s_auto <= 1'b1;
    if (me === 1'b1) s_me <= 1'b1;
    if (log_wr === 1'b1) s_log <= 1'b1;
    if (log_wr === 1'b1) s_word <= log_w;
    if (cyc == 8000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bready <= 1'b0;
    chk_val("write resp", 32'h0, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk_val("read resp", 32'h0, {30'h0, rd_r});
    chk_val("read data", {16'h0000, e}, rd_d);
  endtask : rd_chk
  task automatic cmd(input logic [15:0] w, input int gap);
    {s_t1, s_t2, s_auto, s_me, s_log} = 5'h00;
    rie_bc_model_i.send(w, gap);
    repeat (2) @(posedge clk);
  endtask : cmd
  task automatic buf_step(input logic c, input logic [7:0] i, input logic [15:0] e);
    @(posedge clk);
    step <= 1'b1;
    circ <= c;
    idx <= i;
    @(posedge clk);
    step <= 1'b0;
    rd_chk(rie_pkg::OFS_IRQ_PENDING, e);
  endtask : buf_step

  initial begin
    {rst, awv, wv, bready, arv, rready, step, circ} = 8'h80;
    {awaddr, araddr, idx, wdata, t2_addr} = '0;
    t2_addr = 5'h05;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(rie_pkg::OFS_IRQ_ENABLE, 16'h0000);
    rd_chk(rie_pkg::OFS_IRQ_PENDING, 16'h0000);
    rd_chk(rie_pkg::OFS_IRQ_OUTPUT_ENABLE, 16'h0000);
    rd(8'h40);
    chk_val("unmapped resp", {30'h0, rie_pkg::RESP_SLVERR}, {30'h0, rd_r});
    chk_val("unmapped data", 32'h0, rd_d);
    wr(rie_pkg::OFS_IRQ_ENABLE, 16'hFFFF);
    rd_chk(rie_pkg::OFS_IRQ_ENABLE, 16'hFDFF);
    wr(rie_pkg::OFS_IRQ_ENABLE, 16'hF000);
    wr(rie_pkg::OFS_IRQ_OUTPUT_ENABLE, 16'hF000);
    wr(rie_pkg::OFS_T2_CONFIG, 16'h0003);
    wr(rie_pkg::OFS_ILLEGAL_TABLE0, 16'h0008);
    $display("reset and setup done");
    foreach (rows[i]) begin
      cmd(rows[i].word, i);
      chk_bit("t1 request", rows[i].t1, s_t1);
      chk_bit("t2 request", rows[i].t2, s_t2);
      chk_bit("auto reset", rows[i].t2, s_auto);
      chk_bit("me response", rows[i].me, s_me);
      chk_bit("irq", rows[i].pend == 16'h0000, irq_n);
      chk_bit("log write", rows[i].pend != 16'h0000, s_log);
      if (rows[i].pend != 16'h0000) chk_val("log word", {16'h0000, rows[i].pend}, {16'h0000, s_word});
      rd_chk(rie_pkg::OFS_IRQ_PENDING, rows[i].pend);
      chk_bit("irq after read", 1'b1, irq_n);
      $display("row %0d done", i);
    end
    cmd(16'h2862, 0);
    cmd(16'hF882, 3);
    rd_chk(rie_pkg::OFS_IRQ_PENDING, 16'h3000);
    rd_chk(rie_pkg::OFS_IRQ_PENDING, 16'h0000);
    $display("accumulate done");
    wr(rie_pkg::OFS_IRQ_ENABLE, 16'h0000);
    cmd(16'h2C08, 1);
    chk_bit("t2 request disabled", 1'b1, s_t2);
    cmd(16'h2862, 1);
    chk_bit("log disabled", 1'b0, s_log);
    chk_bit("irq disabled", 1'b1, irq_n);
    rd_chk(rie_pkg::OFS_IRQ_PENDING, 16'h0000);
    wr(rie_pkg::OFS_IRQ_ENABLE, 16'hF000);
    wr(rie_pkg::OFS_IRQ_OUTPUT_ENABLE, 16'h0000);
    wr(rie_pkg::OFS_T2_CONFIG, 16'h0000);
    cmd(16'hFFE8, 0);
    chk_bit("t1 without broadcast", 1'b0, s_t1);
    cmd(16'h2C08, 0);
    chk_bit("auto reset off", 1'b0, s_auto);
    chk_bit("irq polled only", 1'b1, irq_n);
    rd_chk(rie_pkg::OFS_IRQ_PENDING, 16'h8000);
    $display("disabled paths done");
    buf_step(1'b0, 8'h02, 16'h0000);
    buf_step(1'b0, 8'h01, 16'h4000);
    wr(rie_pkg::OFS_CIRC_PRESET, 16'h0002);
    buf_step(1'b1, 8'h05, 16'h0000);
    buf_step(1'b1, 8'h04, 16'h4000);
    wr(rie_pkg::OFS_ILLEGAL_TABLE0, 16'h0000);
    cmd(16'h2862, 0);
    chk_bit("zero table legal", 1'b0, s_me);
    $display("index and table done");
    wr(rie_pkg::OFS_EVENT_STATUS, 16'hFFFF);
    wr(rie_pkg::OFS_EVENT_MASK, 16'h0000);
    wr(rie_pkg::OFS_ILLEGAL_TABLE0, 16'h0008);
    rd_chk(rie_pkg::OFS_ILLEGAL_TABLE0, 16'h0008);
    cmd(16'h2862, 0);
    chk_bit("int masked", 1'b0, int_o);
    wr(rie_pkg::OFS_EVENT_MASK, 16'h2000);
    @(posedge clk);
    chk_bit("int unmasked", 1'b1, int_o);
    rd_chk(rie_pkg::OFS_EVENT_STATUS, 16'h2000);
    wr(rie_pkg::OFS_EVENT_STATUS, 16'h2000);
    @(posedge clk);
    chk_bit("int cleared", 1'b0, int_o);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(rie_pkg::OFS_IRQ_ENABLE, 16'h0000);
    $display("interrupt and second reset done");
    complete_run();
  end
endmodule : rie_event_bits_tb
